//--- usm_pkg.sv
// Shared constants, types and helpers for the serial port SPI master mode
package usm_pkg;
  localparam int unsigned FRAME_BITS = 8;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam logic [3:0] FRAME_BITS_W = 4'h8;
  localparam logic [1:0] MODE_MSPI = 2'h3;
  localparam int unsigned DIV_W = 12;
  localparam logic [11:0] DIV_RESET = 12'h000;
  localparam logic [1:0] RX_DEPTH = 2'h2;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] ERR_ZERO = 3'h0;
  localparam real CLOCK_MHZ = 10.0;

  typedef enum logic
  {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } usm_state_t;

  // Wire position of bit number n inside the byte for the chosen order
  function automatic logic [2:0] bitPos(input logic [2:0] n, input logic lsbFirst);
    return lsbFirst ? n : 3'h7 - n;
  endfunction
endpackage

//--- usm_baud_if.sv
// Link between the transfer engine and the baud tick generator
`timescale 1ns/1ns
`default_nettype none
interface usm_baud_if;
  logic run;
  logic [usm_pkg::DIV_W-1:0] divisor;
  logic tick;
  modport gen (input run, input divisor, output tick);
  modport user (output run, output divisor, input tick);
endinterface
`default_nettype wire

//--- usm_baud_gen.sv
// Baud tick generator: one tick per transfer clock half period
`timescale 1ns/1ns
`default_nettype none
module usm_baud_gen
(
  input wire logic clock,
  input wire logic rstSyncN,
  usm_baud_if.gen baud
);
  import usm_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // ----------------------------------------
  // Half period counter
  // ----------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!baud.run)
    begin
      // Restart on each idle so the first edge always gets a full half period
      cnt_d = DIV_RESET;
    end
    else if (cnt_q >= baud.divisor)
    begin
      cnt_d = DIV_RESET;
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + 12'h001;
    end
  end

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      cnt_q <= DIV_RESET;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign baud.tick = tick_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstSyncN);

  a_tick_spacing: assert property ((tick_q && baud.divisor != DIV_RESET) |=> !tick_q)
    else $error("baud tick repeated with nonzero divisor");
endmodule
`default_nettype wire

//--- usm_spi_master.sv
// Serial port in SPI master mode: transfer engine, buffers and pin control
`timescale 1ns/1ns
`default_nettype none
module usm_spi_master
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] portModeSel,
  input wire logic txEnable,
  input wire logic rxEnable,
  input wire logic bitOrderLsb,
  input wire logic clockPhase,
  input wire logic clockPolarity,
  input wire logic clockPinDirection,
  input wire logic baudWrite,
  input wire logic [usm_pkg::DIV_W-1:0] baudWriteValue,
  input wire logic dataWrite,
  input wire logic [7:0] dataWriteByte,
  input wire logic dataRead,
  input wire logic txCompleteClear,
  input wire logic serialIn,
  output logic [7:0] dataReadByte,
  output logic txBufferEmpty,
  output logic txComplete,
  output logic rxComplete,
  output logic framingError,
  output logic dataOverrun,
  output logic parityError,
  output logic serialOut,
  output logic serialOutOe,
  output logic serialInOverride,
  output logic transferClock,
  output logic transferClockOe
);
  import usm_pkg::*;

  // ----------------------------------------
  // Reset release and input synchroniser
  // ----------------------------------------
  logic [1:0] rstPipe_q;
  logic rstSyncN;
  logic sinMeta_q;
  logic sinSync_q;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rstPipe_q <= 2'h0;
    end
    else
    begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe_q[1];

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      sinMeta_q <= 1'b0;
      sinSync_q <= 1'b0;
    end
    else
    begin
      sinMeta_q <= serialIn;
      sinSync_q <= sinMeta_q;
    end
  end

  // ----------------------------------------
  // Baud divisor and tick generator
  // ----------------------------------------
  logic [DIV_W-1:0] baudDiv_q;
  logic [DIV_W-1:0] baudDiv_d;
  usm_baud_if baudLink ();

  always_comb
  begin
    baudDiv_d = baudWrite ? baudWriteValue : baudDiv_q;
  end

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      baudDiv_q <= DIV_RESET;
    end
    else
    begin
      baudDiv_q <= baudDiv_d;
    end
  end

  usm_baud_gen baudGen
  (
    .clock(clock),
    .rstSyncN(rstSyncN),
    .baud(baudLink.gen)
  );

  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  usm_state_t state_q;
  usm_state_t state_d;
  logic [7:0] txBuf_q;
  logic [7:0] txBuf_d;
  logic txBufEmpty_q;
  logic txBufEmpty_d;
  logic [7:0] txShift_q;
  logic [7:0] txShift_d;
  logic [7:0] rxShift_q;
  logic [7:0] rxShift_d;
  logic [4:0] edgeCnt_q;
  logic [4:0] edgeCnt_d;
  logic sck_q;
  logic sck_d;
  logic sout_q;
  logic sout_d;
  logic txDone_q;
  logic txDone_d;
  logic soutOe_q;
  logic soutOe_d;
  logic sinOvr_q;
  logic sinOvr_d;
  logic sckOe_q;
  logic sckOe_d;
  logic masterMode;
  logic acceptWrite;
  logic doLoad;
  logic frameDone;
  logic sampleStb;
  logic setupStb;
  logic [3:0] nextBit;

  // both mode bits must be one
  assign masterMode = (portModeSel == MODE_MSPI);
  // writes need the transmitter; full buffer ignores writes
  assign acceptWrite = dataWrite && txBufEmpty_q && masterMode && txEnable;
  assign baudLink.divisor = baudDiv_q;

  always_comb
  begin
    state_d = state_q;
    txBuf_d = txBuf_q;
    txBufEmpty_d = txBufEmpty_q;
    txShift_d = txShift_q;
    rxShift_d = rxShift_q;
    edgeCnt_d = edgeCnt_q;
    sck_d = sck_q;
    sout_d = sout_q;
    txDone_d = txDone_q;
    doLoad = 1'b0;
    frameDone = 1'b0;
    sampleStb = 1'b0;
    setupStb = 1'b0;
    nextBit = {1'b0, edgeCnt_q[3:1]} + {3'h0, ~clockPhase};
    unique case (state_q)
      ST_IDLE:
      begin
        // idle clock level is the polarity
        sck_d = clockPolarity;
        sout_d = IDLE_LEVEL;
        doLoad = !txBufEmpty_q && masterMode;
      end
      ST_SHIFT:
      begin
        if (baudLink.tick)
        begin
          sck_d = ~sck_q;
          edgeCnt_d = edgeCnt_q + 5'h01;
          // sample and setup on opposite edges
          if (edgeCnt_q[0] == clockPhase)
          begin
            sampleStb = 1'b1;
            rxShift_d[bitPos(edgeCnt_q[3:1], bitOrderLsb)] = sinSync_q;
          end
          else
          begin
            setupStb = 1'b1;
            if (nextBit < FRAME_BITS_W)
            begin
              sout_d = txShift_q[bitPos(nextBit[2:0], bitOrderLsb)];
            end
          end
          // eight bits make sixteen clock edges
          if (edgeCnt_q == FRAME_EDGES - 5'h01)
          begin
            frameDone = 1'b1;
            // chain the buffered byte or go idle
            doLoad = !txBufEmpty_q;
            if (txBufEmpty_q)
            begin
              state_d = ST_IDLE;
              sout_d = IDLE_LEVEL;
              txDone_d = txDone_q || !acceptWrite;
            end
          end
        end
      end
    endcase
    // buffer moves to shifter only when it is free
    if (doLoad)
    begin
      state_d = ST_SHIFT;
      txShift_d = txBuf_q;
      txBufEmpty_d = 1'b1;
      edgeCnt_d = 5'h00;
      sck_d = clockPolarity;
      // Phase zero presents the first bit before the leading edge
      if (!clockPhase)
      begin
        sout_d = txBuf_q[bitPos(3'h0, bitOrderLsb)];
      end
    end
    // a write starts a full duplex transfer
    if (acceptWrite)
    begin
      txBuf_d = dataWriteByte;
      txBufEmpty_d = 1'b0;
    end
    // write one clears; a same cycle set wins
    if (txCompleteClear && !(frameDone && txBufEmpty_q && !acceptWrite))
    begin
      txDone_d = 1'b0;
    end
    // pin held until pending bytes are out
    soutOe_d = masterMode && (txEnable || state_q == ST_SHIFT || !txBufEmpty_q);
    // receiver owns serial in only when enabled
    sinOvr_d = masterMode && rxEnable;
    sckOe_d = clockPinDirection;
  end

  // Keeps counting through a chained reload so the gap stays one half period
  assign baudLink.run = (state_q == ST_SHIFT);

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state_q <= ST_IDLE;
      txBuf_q <= BYTE_ZERO;
      txBufEmpty_q <= 1'b1;
      txShift_q <= BYTE_ZERO;
      rxShift_q <= BYTE_ZERO;
      edgeCnt_q <= 5'h00;
      sck_q <= 1'b0;
      sout_q <= IDLE_LEVEL;
      txDone_q <= 1'b0;
      soutOe_q <= 1'b0;
      sinOvr_q <= 1'b0;
      sckOe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      txBuf_q <= txBuf_d;
      txBufEmpty_q <= txBufEmpty_d;
      txShift_q <= txShift_d;
      rxShift_q <= rxShift_d;
      edgeCnt_q <= edgeCnt_d;
      sck_q <= sck_d;
      sout_q <= sout_d;
      txDone_q <= txDone_d;
      soutOe_q <= soutOe_d;
      sinOvr_q <= sinOvr_d;
      sckOe_q <= sckOe_d;
    end
  end

  // ----------------------------------------
  // Receive buffer, two deep
  // ----------------------------------------
  logic [7:0] rxBuf_q [0:1];
  logic [7:0] rxBuf_d [0:1];
  logic [1:0] rxCount_q;
  logic [1:0] rxCount_d;
  logic rxPush;
  logic rxPop;

  assign rxPush = frameDone && rxEnable;
  assign rxPop = dataRead && (rxCount_q != 2'h0);

  always_comb
  begin
    rxBuf_d = rxBuf_q;
    rxCount_d = rxCount_q;
    if (!rxEnable)
    begin
      // Disabling the receiver flushes unread bytes
      rxCount_d = 2'h0;
    end
    else
    begin
      if (rxPop)
      begin
        rxBuf_d[0] = rxBuf_q[1];
        rxCount_d = rxCount_q - 2'h1;
      end
      // full buffer drops the newest byte
      if (rxPush && rxCount_d < RX_DEPTH)
      begin
        rxBuf_d[rxCount_d[0]] = rxShift_d;
        rxCount_d = rxCount_d + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      rxBuf_q[0] <= BYTE_ZERO;
      rxBuf_q[1] <= BYTE_ZERO;
      rxCount_q <= 2'h0;
    end
    else
    begin
      rxBuf_q <= rxBuf_d;
      rxCount_q <= rxCount_d;
    end
  end

  // ----------------------------------------
  // Status and pin outputs
  // ----------------------------------------
  logic [2:0] errFlags_q;
  logic rxComplete_q;

  // error flags unused in this mode
  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      errFlags_q <= ERR_ZERO;
      rxComplete_q <= 1'b0;
    end
    else
    begin
      errFlags_q <= ERR_ZERO;
      rxComplete_q <= (rxCount_d != 2'h0);
    end
  end

  assign dataReadByte = rxBuf_q[0];
  assign txBufferEmpty = txBufEmpty_q;
  assign txComplete = txDone_q;
  assign rxComplete = rxComplete_q;
  assign framingError = errFlags_q[0];
  assign dataOverrun = errFlags_q[1];
  assign parityError = errFlags_q[2];
  assign serialOut = sout_q;
  assign serialOutOe = soutOe_q;
  assign serialInOverride = sinOvr_q;
  assign transferClock = sck_q;
  assign transferClockOe = sckOe_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [3:0] sampleCnt_q;

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      sampleCnt_q <= 4'h0;
    end
    else
    begin
      sampleCnt_q <= doLoad ? 4'h0 : sampleCnt_q + {3'h0, sampleStb};
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstSyncN);

  a_frame_bits: assert property (frameDone |-> (sampleCnt_q + {3'h0, sampleStb}) == FRAME_BITS_W)
    else $error("frame did not sample eight bits");
  a_sample_edge: assert property (sampleStb |=> sck_q == ~(clockPolarity ^ clockPhase))
    else $error("sample on wrong clock edge");
  a_setup_edge: assert property (setupStb |=> sck_q == (clockPolarity ^ clockPhase))
    else $error("setup on wrong clock edge");
  a_idle_levels: assert property (state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> sout_q && sck_q == $past(clockPolarity))
    else $error("idle line levels wrong");
  a_mode_gate: assert property (!masterMode |-> !acceptWrite ##1 !soutOe_q)
    else $error("transfer outside master mode");
  a_div_reset: assert property ($rose(rstSyncN) |-> baudDiv_q == DIV_RESET)
    else $error("divisor not zero after reset");
  a_rx_overflow: assert property (rxPush && !rxPop && rxCount_q == RX_DEPTH |=> rxCount_q == RX_DEPTH && dataReadByte == $past(rxBuf_q[0]))
    else $error("overflow disturbed older bytes");
  a_txc_pending: assert property ($rose(txDone_q) |-> txBufEmpty_q && state_q == ST_IDLE)
    else $error("complete set with data pending");
  a_buffer_take: assert property (acceptWrite |=> !txBufEmpty_q ##1 (state_q == ST_SHIFT))
    else $error("written byte not queued");
  a_err_zero: assert property (!framingError && !dataOverrun && !parityError)
    else $error("receiver error flag set");
endmodule
`default_nettype wire

//--- usm_spi_slave_model.sv
// Behavioural SPI slave facing the serial port master
`timescale 1ns/1ns
`default_nettype none
module usm_spi_slave_model
(
  input wire logic sck,
  input wire logic mosi,
  input wire logic selectN,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsbFirst,
  input wire logic [7:0] firstByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] txByte;
  logic [2:0] txNo;
  logic [2:0] rxNo;
  logic outBit;
  // Released line shows the inverse of the last bit, so a stale copy never passes
  assign miso = selectN ? ~outBit : outBit;
  function automatic logic pick(input logic [7:0] b, input logic [2:0] n);
    return lsbFirst ? b[n] : b[3'h7 - n];
  endfunction
  initial
  begin
    outBit = 1'b0;
    rxByte = 8'h00;
  end
  // Each frame sends the next byte up, so lost or repeated frames show
  always @(negedge selectN)
  begin
    txByte = firstByte;
    txNo = 3'h0;
    rxNo = 3'h0;
    outBit = pick(firstByte, 3'h0);
  end
  always @(sck)
  begin
    if (!selectN)
    begin
      if ((sck !== cpol) ^ cpha)
      begin
        rxByte[lsbFirst ? rxNo : 3'h7 - rxNo] = mosi;
        rxNo = rxNo + 3'h1;
      end
      else
      begin
        if (cpha)
          outBit = pick(txByte, txNo);
        if (txNo == 3'h7)
          txByte = txByte + 8'h01;
        txNo = txNo + 3'h1;
        if (!cpha)
          outBit = pick(txByte, txNo);
      end
    end
  end
endmodule
`default_nettype wire

//--- test_serial_port_spi_master_mode.sv
// Self-checking bench for the serial port SPI master mode
`timescale 1ns/1ns
`default_nettype none
module test_serial_port_spi_master_mode;
  import usm_pkg::*;
  logic clock, rstn, txEnable, rxEnable, bitOrderLsb, clockPhase, clockPolarity;
  logic clockPinDirection, baudWrite, dataWrite, dataRead, txCompleteClear, selectN;
  logic [1:0] portModeSel;
  logic [DIV_W-1:0] baudWriteValue;
  logic [7:0] dataWriteByte, slaveFirst, dataReadByte, slaveRx;
  logic txBufferEmpty, txComplete, rxComplete, framingError, dataOverrun, parityError;
  logic serialOut, serialOutOe, serialInOverride, transferClock, transferClockOe, serialIn;
  logic sckPrev;
  int n_fail, samples_checked, cyc, toggles, gap, badGap, half;

  usm_spi_master usm_spi_master_i (.clock(clock), .rstn(rstn), .portModeSel(portModeSel),
    .txEnable(txEnable), .rxEnable(rxEnable), .bitOrderLsb(bitOrderLsb),
    .clockPhase(clockPhase), .clockPolarity(clockPolarity),
    .clockPinDirection(clockPinDirection), .baudWrite(baudWrite),
    .baudWriteValue(baudWriteValue), .dataWrite(dataWrite), .dataWriteByte(dataWriteByte),
    .dataRead(dataRead), .txCompleteClear(txCompleteClear), .serialIn(serialIn),
    .dataReadByte(dataReadByte), .txBufferEmpty(txBufferEmpty), .txComplete(txComplete),
    .rxComplete(rxComplete), .framingError(framingError), .dataOverrun(dataOverrun),
    .parityError(parityError), .serialOut(serialOut), .serialOutOe(serialOutOe),
    .serialInOverride(serialInOverride), .transferClock(transferClock),
    .transferClockOe(transferClockOe));

  usm_spi_slave_model usm_spi_slave_model_i (.sck(transferClock), .mosi(serialOut),
    .selectN(selectN), .cpol(clockPolarity), .cpha(clockPhase), .lsbFirst(bitOrderLsb),
    .firstByte(slaveFirst), .miso(serialIn), .rxByte(slaveRx));

  // ----------------------------------------
  // Clock, edge monitor and hang guard
  // ----------------------------------------
  always #50 clock = ~clock;
  always @(negedge clock)
  begin
    cyc = cyc + 1;
    if (transferClock !== sckPrev)
    begin
      // half period is divisor plus one
      if (toggles > 0 && gap != half)
        badGap = badGap + 1;
      toggles = toggles + 1;
      gap = 1;
    end
    else
      gap = gap + 1;
    sckPrev = transferClock;
    if (cyc == 5000)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0t timeout", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chkN(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic write_byte(input logic [7:0] b);
    dataWrite = 1'b1;
    dataWriteByte = b;
    tick(1);
    dataWrite = 1'b0;
  endtask
  task automatic read_byte(input logic [7:0] exp);
    chk8(dataReadByte, exp, "rx byte");
    dataRead = 1'b1;
    tick(1);
    dataRead = 1'b0;
    tick(1);
  endtask
  task automatic clear_done();
    txCompleteClear = 1'b1;
    tick(1);
    txCompleteClear = 1'b0;
    chk1(txComplete, 1'b0, "clear");
  endtask
  task automatic wait_high(input logic done);
    int i;
    i = 0;
    while ((done ? txComplete : txBufferEmpty) !== 1'b1 && i < 2000)
    begin
      tick(1);
      i++;
    end
    chk1(done ? txComplete : txBufferEmpty, 1'b1, "flag");
  endtask
  // Format is only touched while no frame runs and the slave is released
  task automatic start(input logic [1:0] m, input logic lsb, input logic [7:0] s);
    {clockPolarity, clockPhase} = m;
    bitOrderLsb = lsb;
    tick(3);
    chk1(transferClock, m[1], "idle clock");
    slaveFirst = s;
    selectN = 1'b0;
    toggles = 0;
    badGap = 0;
    clear_done();
  endtask
  task automatic do_frame(input logic [1:0] m, input logic lsb, input logic [7:0] b, s);
    start(m, lsb, s);
    write_byte(b);
    wait_high(1'b1);
    tick(2);
    selectN = 1'b1;
    chkN(toggles, 2 * FRAME_BITS, "edges");
    chkN(badGap, 0, "rate");
    chk8(slaveRx, b, "mosi");
    chk1(serialOut, IDLE_LEVEL, "idle data");
    read_byte(s);
    chk1(rxComplete, 1'b0, "rx empty");
    $display("test mode %0d done", m);
  endtask
  task automatic set_baud(input logic [DIV_W-1:0] d);
    baudWriteValue = d;
    baudWrite = 1'b1;
    tick(1);
    baudWrite = 1'b0;
    half = int'(d) + 1;
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {clock, rstn, txEnable, rxEnable, bitOrderLsb, clockPhase, clockPolarity} = 7'h00;
    {clockPinDirection, baudWrite, dataWrite, dataRead, txCompleteClear} = 5'h00;
    {portModeSel, baudWriteValue, dataWriteByte, slaveFirst, selectN} = 31'h1;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    toggles = 0;
    gap = 0;
    badGap = 0;
    half = 0;
    sckPrev = 1'b0;
    tick(20);
    rstn = 1'b1;
    tick(3);
    chk1(txBufferEmpty, 1'b1, "empty");
    chk1(txComplete, 1'b0, "done");
    chk1(serialOut, IDLE_LEVEL, "idle data");
    chk8({5'h00, framingError, dataOverrun, parityError}, 8'h00, "errors");
    portModeSel = 2'h2;
    txEnable = 1'b1;
    clockPinDirection = 1'b1;
    write_byte(8'h5a);
    tick(2);
    chk1(txBufferEmpty, 1'b1, "wrong mode");
    chk1(serialOutOe, 1'b0, "pin kept");
    chkN(toggles, 0, "no clock");
    portModeSel = MODE_MSPI;
    txEnable = 1'b0;
    write_byte(8'h5a);
    tick(2);
    chk1(txBufferEmpty, 1'b1, "tx off");
    chk1(serialOutOe, 1'b0, "pin kept");
    txEnable = 1'b1;
    rxEnable = 1'b1;
    tick(2);
    chk1(serialOutOe, 1'b1, "out pin");
    chk1(serialInOverride, 1'b1, "in pin");
    chk1(transferClockOe, 1'b1, "clock pin");
    set_baud(12'h003);
    $display("test setup done");
    for (int m = 0; m < 4; m++)
      do_frame(m[1:0], m[0] ^ m[1], 8'h96 + 8'(m), 8'h4b - 8'(m));
    start(2'h0, 1'b0, 8'h3c);
    write_byte(8'ha1);
    tick(2);
    wait_high(1'b0);
    write_byte(8'h5e);
    tick(1);
    chk1(txBufferEmpty, 1'b0, "held");
    tick(2);
    wait_high(1'b0);
    chk1(txComplete, 1'b0, "first of two");
    write_byte(8'hc7);
    wait_high(1'b1);
    tick(2);
    selectN = 1'b1;
    chkN(toggles, 6 * FRAME_BITS, "chain edges");
    chkN(badGap, 0, "chain gap");
    chk8(slaveRx, 8'hc7, "last mosi");
    read_byte(8'h3c);
    read_byte(8'h3d);
    chk1(rxComplete, 1'b0, "third lost");
    rxEnable = 1'b0;
    tick(2);
    chk1(serialInOverride, 1'b0, "in pin free");
    $display("test chain done");
    report_and_stop();
  end
endmodule
`default_nettype wire
